// >>> src/cpcr_pkg.sv
package cpcr_pkg;

   // Word index of each register; the byte address is four times the index.
   localparam logic [7:0] IDX_ADC_OVERSAMPLE_CTRL  = 8'h0A;
   localparam logic [7:0] IDX_INPUT_AMP_POWER      = 8'h0C;
   localparam logic [7:0] IDX_OUTPUT_MIXER_POWER   = 8'h0D;
   localparam logic [7:0] IDX_HEADPHONE_POWER      = 8'h0E;
   localparam logic [7:0] IDX_LINE_OUTPUT_POWER    = 8'h0F;
   localparam logic [7:0] IDX_SPEAKER_MIXER_POWER  = 8'h10;
   localparam logic [7:0] IDX_SPEAKER_OUTPUT_POWER = 8'h11;
   localparam logic [7:0] IDX_CONVERTER_POWER      = 8'h12;
   localparam logic [7:0] IDX_SYS_CLOCK_PREDIVIDE  = 8'h14;
   localparam logic [7:0] IDX_SYS_CLOCK_RATIO      = 8'h15;
   localparam logic [7:0] IDX_UNMAPPED             = 8'hFF;

   // The six left/right enable registers sit at consecutive indices.
   localparam int         NUM_PAIR_REGS            = 6;

   // Field positions.
   localparam int         OSR_BIT                  = 0;
   localparam int         PAIR_LEFT_BIT            = 1;
   localparam int         PAIR_RIGHT_BIT           = 0;
   localparam int         DACL_BIT                 = 3;
   localparam int         DACR_BIT                 = 2;
   localparam int         ADCL_BIT                 = 1;
   localparam int         ADCR_BIT                 = 0;
   localparam int         HALVE_BIT                = 0;
   localparam int         RATIO_LSB                = 10;
   localparam int         RATIO_MSB                = 13;
   localparam int         MODE_LSB                 = 8;
   localparam int         MODE_MSB                 = 9;

   typedef enum logic [1:0] {
      FAM_256  = 2'b00,
      FAM_272  = 2'b01,
      FAM_250  = 2'b10,
      FAM_RSVD = 2'b11
   } cpcr_family_e;

   // Reset values.
   localparam logic       OSR_RESET                = 1'b1;
   localparam logic [1:0] PAIR_RESET               = 2'h0;
   localparam logic [3:0] CONV_RESET               = 4'h0;
   localparam logic       HALVE_RESET              = 1'b0;
   localparam logic [3:0] RATIO_CODE_RESET         = 4'h3;
   localparam cpcr_family_e MODE_RESET             = FAM_256;

   // System clock to sample rate ratios for codes 0 to 9 of each family.
   localparam int         NUM_RATIO_CODES          = 10;
   localparam logic [10:0] RATIO_TAB_256 [0:9] = '{11'h040, 11'h080, 11'h0C0, 11'h100,
      11'h180, 11'h200, 11'h300, 11'h400, 11'h580, 11'h600};
   localparam logic [10:0] RATIO_TAB_272 [0:9] = '{11'h044, 11'h088, 11'h0CC, 11'h110,
      11'h198, 11'h220, 11'h330, 11'h440, 11'h5D8, 11'h660};
   localparam logic [10:0] RATIO_TAB_250 [0:9] = '{11'h07D, 11'h07D, 11'h0FA, 11'h0FA,
      11'h177, 11'h1F4, 11'h2EE, 11'h3E8, 11'h3E8, 11'h5DC};

endpackage : cpcr_pkg

// >>> src/cpcr_ahb_slave.sv
`timescale 1ns/10ps
module cpcr_ahb_slave
   import cpcr_pkg::*;
(
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave side.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Register file side.
   output logic [7:0]       rd_idx,
   input  wire logic [15:0] rd_value,
   output logic             wr_en,
   output logic [7:0]       wr_idx,
   output logic [15:0]      wr_data
);

   logic accept;
   logic wr_pend;

   assign accept    = hsel & htrans[1] & hready;
   // Addresses above the register window fold onto an index that nothing decodes.
   assign rd_idx    = (haddr[31:10] == 22'h0) ? haddr[9:2] : IDX_UNMAPPED;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr_en     = wr_pend;
   assign wr_data   = hwdata[15:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx  <= IDX_UNMAPPED;
      end else begin
         wr_pend <= accept & hwrite;
         wr_idx  <= rd_idx;
      end
   end

   // Read data is captured at the address phase; rd_value already includes a
   // write finishing in the same cycle, so back-to-back write then read is safe.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (accept & !hwrite) begin
         hrdata <= {16'h0000, rd_value};
      end else begin
         hrdata <= 32'h00000000;
      end
   end

endmodule : cpcr_ahb_slave

// >>> src/cpcr_ratio_decode.sv
`timescale 1ns/10ps
module cpcr_ratio_decode
   import cpcr_pkg::*;
(
   // Clock family and ratio code.
   input  wire cpcr_family_e mode,
   input  wire logic [3:0]   code,
   // Decoded ratio.
   output logic [10:0]       ratio,
   output logic              valid
);

   always_comb begin
      ratio = 11'h000;
      valid = 1'b0;
      if (code < 4'(NUM_RATIO_CODES)) begin
         case (mode)
            FAM_256: begin
               ratio = RATIO_TAB_256[code];
               valid = 1'b1;
            end
            FAM_272: begin
               ratio = RATIO_TAB_272[code];
               valid = 1'b1;
            end
            FAM_250: begin
               ratio = RATIO_TAB_250[code];
               valid = 1'b1;
            end
            default: begin
               ratio = 11'h000;
               valid = 1'b0;
            end
         endcase
      end
   end

endmodule : cpcr_ratio_decode

// >>> src/cpcr_regs.sv
`timescale 1ns/10ps
module cpcr_regs
   import cpcr_pkg::*;
(
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite register bus.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Converter oversampling.
   output logic             adc_oversample_high,
   // Analogue block enables.
   output logic             left_input_amp_on,
   output logic             right_input_amp_on,
   output logic             left_out_mixer_on,
   output logic             right_out_mixer_on,
   output logic             left_headphone_on,
   output logic             right_headphone_on,
   output logic             left_line_out_on,
   output logic             right_line_out_on,
   output logic             left_speaker_mixer_on,
   output logic             right_speaker_mixer_on,
   output logic             left_speaker_out_on,
   output logic             right_speaker_out_on,
   output logic             left_dac_on,
   output logic             right_dac_on,
   output logic             left_adc_on,
   output logic             right_adc_on,
   // System clock setup.
   output logic             master_clock_halve,
   output cpcr_family_e     sys_clock_family_mode,
   output logic [3:0]       sys_clock_ratio_code,
   output logic [10:0]      system_clock_fs_ratio,
   output logic [11:0]      master_clock_fs_ratio,
   output logic             clock_setup_valid,
   output logic             clock_setup_unsupported
);

   logic         wr_en;
   logic [7:0]   wr_idx;
   logic [15:0]  wr_data;
   logic [7:0]   rd_idx;
   logic [15:0]  rd_value;

   logic [1:0]   pair_en   [NUM_PAIR_REGS];
   logic [1:0]   next_pair [NUM_PAIR_REGS];
   logic         next_osr;
   logic [3:0]   conv_en;
   logic [3:0]   next_conv;
   logic         next_halve;
   cpcr_family_e next_mode;
   logic [3:0]   next_code;
   logic [10:0]  next_fs_ratio;
   logic         next_ratio_valid;

   // Maps an index onto a slot of the left/right enable registers, or -1.
   function automatic int pair_slot(input logic [7:0] idx);
      int slot;
      slot = -1;
      if (idx >= IDX_INPUT_AMP_POWER && idx <= IDX_SPEAKER_OUTPUT_POWER) begin
         slot = int'(idx - IDX_INPUT_AMP_POWER);
      end
      return slot;
   endfunction : pair_slot

   // hsize is accepted but ignored: every register is a whole word.
   cpcr_ahb_slave u_bus (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hwdata    (hwdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .rd_idx    (rd_idx),
      .rd_value  (rd_value),
      .wr_en     (wr_en),
      .wr_idx    (wr_idx),
      .wr_data   (wr_data)
   );

   cpcr_ratio_decode u_ratio (
      .mode  (next_mode),
      .code  (next_code),
      .ratio (next_fs_ratio),
      .valid (next_ratio_valid)
   );

   // Left/right enable pairs.
   genvar g;
   generate
      for (g = 0; g < NUM_PAIR_REGS; g++) begin : g_pair
         always_comb begin
            next_pair[g] = pair_en[g];
            if (wr_en && pair_slot(wr_idx) == g) begin
               next_pair[g] = wr_data[1:0];
            end
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pair_en[g] <= PAIR_RESET;
            end else begin
               pair_en[g] <= next_pair[g];
            end
         end
      end
   endgenerate

   assign left_input_amp_on      = pair_en[0][PAIR_LEFT_BIT];
   assign right_input_amp_on     = pair_en[0][PAIR_RIGHT_BIT];
   assign left_out_mixer_on      = pair_en[1][PAIR_LEFT_BIT];
   assign right_out_mixer_on     = pair_en[1][PAIR_RIGHT_BIT];
   assign left_headphone_on      = pair_en[2][PAIR_LEFT_BIT];
   assign right_headphone_on     = pair_en[2][PAIR_RIGHT_BIT];
   assign left_line_out_on       = pair_en[3][PAIR_LEFT_BIT];
   assign right_line_out_on      = pair_en[3][PAIR_RIGHT_BIT];
   assign left_speaker_mixer_on  = pair_en[4][PAIR_LEFT_BIT];
   assign right_speaker_mixer_on = pair_en[4][PAIR_RIGHT_BIT];
   assign left_speaker_out_on    = pair_en[5][PAIR_LEFT_BIT];
   assign right_speaker_out_on   = pair_en[5][PAIR_RIGHT_BIT];
   assign left_dac_on            = conv_en[DACL_BIT];
   assign right_dac_on           = conv_en[DACR_BIT];
   assign left_adc_on            = conv_en[ADCL_BIT];
   assign right_adc_on           = conv_en[ADCR_BIT];

   // Next values of the single registers.
   always_comb begin
      next_osr   = adc_oversample_high;
      next_conv  = conv_en;
      next_halve = master_clock_halve;
      next_mode  = sys_clock_family_mode;
      next_code  = sys_clock_ratio_code;
      if (wr_en) begin
         if (wr_idx == IDX_ADC_OVERSAMPLE_CTRL) begin
            next_osr = wr_data[OSR_BIT];
         end else if (wr_idx == IDX_CONVERTER_POWER) begin
            next_conv = wr_data[DACL_BIT:ADCR_BIT];
         end else if (wr_idx == IDX_SYS_CLOCK_PREDIVIDE) begin
            next_halve = wr_data[HALVE_BIT];
         end else if (wr_idx == IDX_SYS_CLOCK_RATIO) begin
            next_mode = cpcr_family_e'(wr_data[MODE_MSB:MODE_LSB]);
            next_code = wr_data[RATIO_MSB:RATIO_LSB];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         adc_oversample_high <= OSR_RESET;
      end else begin
         adc_oversample_high <= next_osr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_en <= CONV_RESET;
      end else begin
         conv_en <= next_conv;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         master_clock_halve    <= HALVE_RESET;
         sys_clock_family_mode <= MODE_RESET;
         sys_clock_ratio_code  <= RATIO_CODE_RESET;
      end else begin
         master_clock_halve    <= next_halve;
         sys_clock_family_mode <= next_mode;
         sys_clock_ratio_code  <= next_code;
      end
   end

   // Derived clock setup, updated on the same edge as the fields it follows.
   // Reserved codes are stored as written but flagged, since software may still
   // read back what it wrote.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         system_clock_fs_ratio   <= RATIO_TAB_256[RATIO_CODE_RESET];
         master_clock_fs_ratio   <= {1'b0, RATIO_TAB_256[RATIO_CODE_RESET]};
         clock_setup_valid       <= 1'b1;
         clock_setup_unsupported <= 1'b0;
      end else begin
         system_clock_fs_ratio   <= next_fs_ratio;
         // The master clock runs twice as fast per sample when it is halved.
         master_clock_fs_ratio   <= next_halve ? {next_fs_ratio, 1'b0}
                                               : {1'b0, next_fs_ratio};
         clock_setup_valid       <= next_ratio_valid;
         clock_setup_unsupported <= !next_osr && next_mode == FAM_250;
      end
   end

   // Read mux over next values; unmapped and reserved bits read as zero.
   always_comb begin
      rd_value = 16'h0000;
      if (pair_slot(rd_idx) >= 0) begin
         rd_value[1:0] = next_pair[pair_slot(rd_idx)];
      end else if (rd_idx == IDX_ADC_OVERSAMPLE_CTRL) begin
         rd_value[OSR_BIT] = next_osr;
      end else if (rd_idx == IDX_CONVERTER_POWER) begin
         rd_value[DACL_BIT:ADCR_BIT] = next_conv;
      end else if (rd_idx == IDX_SYS_CLOCK_PREDIVIDE) begin
         rd_value[HALVE_BIT] = next_halve;
      end else if (rd_idx == IDX_SYS_CLOCK_RATIO) begin
         rd_value[RATIO_MSB:RATIO_LSB] = next_code;
         rd_value[MODE_MSB:MODE_LSB]   = next_mode;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_osr_write;
      wr_en && wr_idx == IDX_ADC_OVERSAMPLE_CTRL
         |=> adc_oversample_high == $past(wr_data[OSR_BIT]);
   endproperty
   a_osr_write: assert property (p_osr_write) else $error("oversample bit not written");

   property p_unsupported_flag;
      ##1 (!adc_oversample_high && sys_clock_family_mode == FAM_250) |-> clock_setup_unsupported;
   endproperty
   a_unsupported_flag: assert property (p_unsupported_flag)
      else $error("bad setup not flagged");

   property p_input_amp;
      wr_en && wr_idx == IDX_INPUT_AMP_POWER
         |=> {left_input_amp_on, right_input_amp_on} == $past(wr_data[1:0]);
   endproperty
   a_input_amp: assert property (p_input_amp) else $error("input amp enables wrong");

   property p_out_mixer;
      wr_en && wr_idx == IDX_OUTPUT_MIXER_POWER
         |=> {left_out_mixer_on, right_out_mixer_on} == $past(wr_data[1:0]);
   endproperty
   a_out_mixer: assert property (p_out_mixer) else $error("output mixer enables wrong");

   property p_headphone;
      wr_en && wr_idx == IDX_HEADPHONE_POWER
         |=> {left_headphone_on, right_headphone_on} == $past(wr_data[1:0]);
   endproperty
   a_headphone: assert property (p_headphone) else $error("headphone enables wrong");

   property p_line_out;
      wr_en && wr_idx == IDX_LINE_OUTPUT_POWER
         |=> {left_line_out_on, right_line_out_on} == $past(wr_data[1:0]);
   endproperty
   a_line_out: assert property (p_line_out) else $error("line output enables wrong");

   property p_spk_mixer;
      wr_en && wr_idx == IDX_SPEAKER_MIXER_POWER
         |=> {left_speaker_mixer_on, right_speaker_mixer_on} == $past(wr_data[1:0]);
   endproperty
   a_spk_mixer: assert property (p_spk_mixer) else $error("speaker mixer bits wrong");

   property p_spk_out;
      wr_en && wr_idx == IDX_SPEAKER_OUTPUT_POWER
         |=> {left_speaker_out_on, right_speaker_out_on} == $past(wr_data[1:0]);
   endproperty
   a_spk_out: assert property (p_spk_out) else $error("speaker output enables wrong");

   property p_converter;
      wr_en && wr_idx == IDX_CONVERTER_POWER
         |=> {left_dac_on, right_dac_on, left_adc_on, right_adc_on} == $past(wr_data[3:0]);
   endproperty
   a_converter: assert property (p_converter) else $error("converter enables wrong");

   property p_halve;
      ##1 master_clock_fs_ratio == (master_clock_halve ? {system_clock_fs_ratio, 1'b0}
                                                       : {1'b0, system_clock_fs_ratio});
   endproperty
   a_halve: assert property (p_halve) else $error("master clock ratio wrong");

   property p_ratio_256;
      ##1 (sys_clock_family_mode == FAM_256 && sys_clock_ratio_code == 4'h9)
         |-> system_clock_fs_ratio == 11'h600 && clock_setup_valid;
   endproperty
   a_ratio_256: assert property (p_ratio_256) else $error("256 family ratio wrong");

   property p_ratio_272;
      ##1 (sys_clock_family_mode == FAM_272 && sys_clock_ratio_code == 4'h8)
         |-> system_clock_fs_ratio == 11'h5D8;
   endproperty
   a_ratio_272: assert property (p_ratio_272) else $error("272 family ratio wrong");

   property p_reserved_code;
      ##1 (sys_clock_ratio_code > 4'h9 || sys_clock_family_mode == FAM_RSVD)
         |-> !clock_setup_valid;
   endproperty
   a_reserved_code: assert property (p_reserved_code) else $error("reserved accepted");

   property p_ratio_250;
      ##1 (sys_clock_family_mode == FAM_250 && sys_clock_ratio_code == 4'h1)
         |-> system_clock_fs_ratio == 11'h07D;
   endproperty
   a_ratio_250: assert property (p_ratio_250) else $error("250 family ratio wrong");

   property p_hold;
      !wr_en |=> $stable(conv_en) && $stable(adc_oversample_high) && $stable(master_clock_halve)
         && $stable(sys_clock_ratio_code) && $stable(sys_clock_family_mode)
         && $stable({pair_en[0], pair_en[1], pair_en[2], pair_en[3], pair_en[4], pair_en[5]});
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without write");

   property p_halve_write;
      wr_en && wr_idx == IDX_SYS_CLOCK_PREDIVIDE
         |=> master_clock_halve == $past(wr_data[HALVE_BIT]);
   endproperty
   a_halve_write: assert property (p_halve_write) else $error("halve not written");

   property p_ratio_write;
      wr_en && wr_idx == IDX_SYS_CLOCK_RATIO
         |=> sys_clock_ratio_code == $past(wr_data[RATIO_MSB:RATIO_LSB])
         && sys_clock_family_mode == $past(wr_data[MODE_MSB:MODE_LSB]);
   endproperty
   a_ratio_write: assert property (p_ratio_write) else $error("ratio not written");

   property p_read_back;
      hsel && htrans[1] && hready && !hwrite && rd_idx == IDX_CONVERTER_POWER
         |=> hrdata == {28'h0000000, left_dac_on, right_dac_on, left_adc_on, right_adc_on};
   endproperty
   a_read_back: assert property (p_read_back) else $error("read back differs");

endmodule : cpcr_regs

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import cpcr_pkg::*;

   logic              hclk    = 1'b0;
   logic              hresetn = 1'b0;
   logic              hsel    = 1'b0;
   logic [31:0]       haddr   = 32'h0;
   logic [1:0]        htrans  = 2'h0;
   logic              hwrite  = 1'b0;
   logic [2:0]        hsize   = 3'h2;
   logic [31:0]       hwdata  = 32'h0;
   wire logic         hready;
   wire logic         hresp;
   wire logic [31:0]  hrdata;
   wire logic [17:0]  flags;
   wire cpcr_family_e fam;
   wire logic [3:0]   code;
   wire logic [10:0]  sys_ratio;
   wire logic [11:0]  mclk_ratio;
   wire logic         valid;
   wire logic         unsup;
   logic [31:0]       seed    = 32'h37;
   logic [15:0]       sh [0:9];
   int                fails   = 0;
   int                comparisons = 0;

   localparam logic [7:0]  IDX [0:9] = '{8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11,
      8'h12, 8'h14, 8'h15};
   localparam logic [15:0] MASK [0:9] = '{16'h0001, 16'h0003, 16'h0003, 16'h0003,
      16'h0003, 16'h0003, 16'h0003, 16'h000F, 16'h0001, 16'h3F00};
   localparam logic [10:0] RT [0:29] = '{11'h040, 11'h080, 11'h0C0, 11'h100, 11'h180,
      11'h200, 11'h300, 11'h400, 11'h580, 11'h600, 11'h044, 11'h088, 11'h0CC, 11'h110,
      11'h198, 11'h220, 11'h330, 11'h440, 11'h5D8, 11'h660, 11'h07D, 11'h07D, 11'h0FA,
      11'h0FA, 11'h177, 11'h1F4, 11'h2EE, 11'h3E8, 11'h3E8, 11'h5DC};
   // Bit 0 clear so that an alias onto the oversampling register would show up.
   localparam logic [31:0] BAD [0:2] = '{32'h0000_002C, 32'h0000_004C, 32'h0000_0428};

   cpcr_regs u_cpcr_regs (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .adc_oversample_high(flags[17]), .left_input_amp_on(flags[16]),
      .right_input_amp_on(flags[15]), .left_out_mixer_on(flags[14]),
      .right_out_mixer_on(flags[13]), .left_headphone_on(flags[12]),
      .right_headphone_on(flags[11]), .left_line_out_on(flags[10]),
      .right_line_out_on(flags[9]), .left_speaker_mixer_on(flags[8]),
      .right_speaker_mixer_on(flags[7]), .left_speaker_out_on(flags[6]),
      .right_speaker_out_on(flags[5]), .left_dac_on(flags[4]), .right_dac_on(flags[3]),
      .left_adc_on(flags[2]), .right_adc_on(flags[1]), .master_clock_halve(flags[0]),
      .sys_clock_family_mode(fam), .sys_clock_ratio_code(code),
      .system_clock_fs_ratio(sys_ratio), .master_clock_fs_ratio(mclk_ratio),
      .clock_setup_valid(valid), .clock_setup_unsupported(unsup));

   always #2.5 hclk = ~hclk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   // One single transfer; the master never assumes a wait-state count.
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= a;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : xfer

   task automatic wr(input int i, input logic [31:0] d);
      logic [31:0] rd;
      xfer(1'b1, {22'h0, IDX[i], 2'b00}, d, rd);
      sh[i] = d[15:0] & MASK[i];
   endtask : wr

   task automatic rd_chk(input int i);
      logic [31:0] rd;
      xfer(1'b0, {22'h0, IDX[i], 2'b00}, rnd(), rd);
      chk(rd, {16'h0, sh[i]});
   endtask : rd_chk

   task automatic sh_reset();
      foreach (sh[i]) sh[i] = 16'h0;
      sh[0] = 16'h0001;
      sh[9] = 16'h0C00;
   endtask : sh_reset

   // Waits one edge first, so a write that just completed has reached the outputs.
   task automatic chk_out();
      logic [10:0] r;
      logic        ok;
      logic [17:0] f;
      @(posedge hclk);
      ok = sh[9][9:8] != 2'b11 && sh[9][13:10] <= 4'h9;
      r  = ok ? RT[sh[9][9:8] * 10 + sh[9][13:10]] : 11'h000;
      f  = {sh[0][0], sh[1][1:0], sh[2][1:0], sh[3][1:0], sh[4][1:0], sh[5][1:0], sh[6][1:0],
            sh[7][3:0], sh[8][0]};
      chk(32'(flags[17]), 32'(f[17]));
      chk(32'(flags[16:5]), 32'(f[16:5]));
      chk(32'(flags[4:1]), 32'(f[4:1]));
      chk(32'(flags[0]), 32'(f[0]));
      chk(32'({code, fam}), 32'(sh[9][13:8]));
      chk(32'(sys_ratio), 32'(r));
      chk(32'(mclk_ratio), 32'(sh[8][0] ? {r, 1'b0} : {1'b0, r}));
      chk(32'({valid, unsup}), 32'({ok, !sh[0][0] && sh[9][9:8] == 2'b10}));
   endtask : chk_out

   initial begin
      logic [31:0] rd;
      int          i;
      sh_reset();
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk_out();
      for (int k = 0; k < 10; k++) rd_chk(k);
      foreach (BAD[k]) begin
         xfer(1'b1, BAD[k], 32'hFFFF_FFFE, rd);
         xfer(1'b0, BAD[k], 32'h0, rd);
         chk(rd, 32'h0);
      end
      for (int k = 0; k < 10; k++) rd_chk(k);
      chk_out();
      for (int n = 0; n < 60; n++) begin
         i = int'(rnd() % 32'd10);
         wr(i, rnd());
         rd_chk(i);
         chk_out();
      end
      // Every family and ratio code, reserved ones too, with and without halving.
      for (int h = 0; h < 2; h++) begin
         wr(0, 32'(h));
         wr(8, 32'(h));
         for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 16; c++) begin
               wr(9, {18'h0, c[3:0], m[1:0], 8'h00});
               chk_out();
            end
         end
      end
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      sh_reset();
      chk_out();
      for (int k = 0; k < 10; k++) rd_chk(k);
      end_of_test();
   end

   initial begin
      #100000;
      fails++;
      end_of_test();
   end

endmodule : tb_top
